// [motor_cmd_pkg.sv]
// Purpose: shared constants for the motor command register bank
// Assumes: byte offsets as seen on the serial register port
// Notes:   loop gain and monitor reset values are plain defaults
package motor_cmd_pkg;
    localparam int          ADDR_W              = 12;
    localparam int          DATA_W              = 32;
    localparam int          ANGLE_W             = 9;
    localparam int          SPEED_W             = 15;
    localparam int          IQ_W                = 10;
    localparam int          CMD_N               = 4;

    localparam logic [11:0] OFS_DEVICE_CMD      = 12'h0EA;
    localparam logic [11:0] OFS_DEBUG_OVERRIDE  = 12'h0EC;
    localparam logic [11:0] OFS_DEBUG_LOOP      = 12'h0EE;
    localparam logic [11:0] OFS_CURRENT_GAINS   = 12'h0F0;
    localparam logic [11:0] OFS_SPEED_GAINS     = 12'h0F2;
    localparam logic [11:0] OFS_MONITOR_ONE     = 12'h0F4;
    localparam logic [11:0] OFS_MONITOR_TWO     = 12'h0F6;

    // device command word fields
    localparam int          CMD_NVM_STORE_BIT   = 31;
    localparam int          CMD_NVM_RECALL_BIT  = 30;
    localparam int          CMD_FAULT_CLR_BIT   = 29;
    localparam int          CMD_RETRY_CLR_BIT   = 28;
    localparam int          CMD_ANGLE_MSB       = 19;
    localparam int          CMD_ANGLE_LSB       = 11;
    localparam int          CMD_KEEPALIVE_BIT   = 10;

    // debug override word fields
    localparam int          DBG_OVERRIDE_BIT    = 31;
    localparam int          DBG_SPEED_MSB       = 30;
    localparam int          DBG_SPEED_LSB       = 16;
    localparam int          DBG_OPEN_LOOP_BIT   = 15;
    localparam int          DBG_FORCE_ALIGN_BIT = 14;
    localparam int          DBG_FORCE_SLOW_BIT  = 13;
    localparam int          DBG_FORCE_IPD_BIT   = 12;
    localparam int          DBG_FORCE_ISD_BIT   = 11;
    localparam int          DBG_ANGLE_SEL_BIT   = 10;
    localparam int          DBG_IQ_MSB          = 9;
    localparam int          DBG_IQ_LSB          = 0;

    // pulse vector order
    localparam int          PULSE_STORE         = 0;
    localparam int          PULSE_RECALL        = 1;
    localparam int          PULSE_FAULT         = 2;
    localparam int          PULSE_RETRY         = 3;

    localparam logic [8:0]  FULL_TURN_DEG       = 9'h168;
    localparam logic [31:0] WORD_ZERO           = 32'h0000_0000;
    localparam logic [31:0] CURRENT_GAINS_RST   = 32'h0000_0000;
    localparam logic [31:0] SPEED_GAINS_RST     = 32'h0000_0000;
    localparam logic [31:0] MONITOR_ONE_RST     = 32'h0000_0000;
    localparam logic [31:0] MONITOR_TWO_RST     = 32'h0000_0000;
endpackage

// [cmd_pulse_gen.sv]
// Purpose: one-cycle command pulses from writes of one
// Assumes: i_wr_hit is high for exactly one cycle per write
// Notes:   a held bit does not repeat; each write makes one pulse
`timescale 1ns/1ps
`default_nettype none
module cmd_pulse_gen
    import motor_cmd_pkg::*;
(
    input  wire logic             i_clk,
    input  wire logic             i_rst_b,
    input  wire logic             i_wr_hit,
    input  wire logic [CMD_N-1:0] i_bits,
    output logic      [CMD_N-1:0] o_pulse
);
    logic [CMD_N-1:0] next_pulse;

    genvar g;
    generate
        for (g = 0; g < CMD_N; g++) begin : g_bit
            assign next_pulse[g] = i_wr_hit & i_bits[g];
        end
    endgenerate

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_pulse <= '0;
        end else begin
            o_pulse <= next_pulse;
        end
    end

    property p_one_shot;
        @(posedge i_clk) disable iff (!i_rst_b)
        (o_pulse != '0) ##1 !i_wr_hit |=> (o_pulse == '0);
    endproperty
    a_one_shot: assert property (p_one_shot)
        else $error("command pulse repeated without a new write");
endmodule
`default_nettype wire

// [align_angle_sel.sv]
// Purpose: alignment angle selection and wrap into one turn
// Assumes: forced angle is 9 bits, so one subtraction wraps it
// Notes:   output is registered
`timescale 1ns/1ps
`default_nettype none
module align_angle_sel
    import motor_cmd_pkg::*;
(
    input  wire logic               i_clk,
    input  wire logic               i_rst_b,
    input  wire logic               i_select_forced,
    input  wire logic [ANGLE_W-1:0] i_forced_angle,
    input  wire logic [ANGLE_W-1:0] i_cfg_angle,
    output logic      [ANGLE_W-1:0] o_angle
);
    logic [ANGLE_W-1:0] next_angle;
    logic [ANGLE_W-1:0] wrapped;

    always_comb begin
        wrapped = i_forced_angle;
        if (i_forced_angle >= FULL_TURN_DEG) begin
            wrapped = i_forced_angle - FULL_TURN_DEG;
        end
        next_angle = i_select_forced ? wrapped : i_cfg_angle;
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_angle <= '0;
        end else begin
            o_angle <= next_angle;
        end
    end

    property p_wrap;
        @(posedge i_clk) disable iff (!i_rst_b)
        i_select_forced |=> (o_angle < FULL_TURN_DEG) &&
            (o_angle == ($past(i_forced_angle) % FULL_TURN_DEG));
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("forced angle not wrapped to one turn");

    property p_source;
        @(posedge i_clk) disable iff (!i_rst_b)
        !i_select_forced |=> (o_angle == $past(i_cfg_angle));
    endproperty
    a_source: assert property (p_source)
        else $error("configured angle not chosen when select is low");
endmodule
`default_nettype wire

// [motor_ctrl_command_regs.sv]
// Purpose: volatile command and algorithm-control registers
// Assumes: serial front end gives one-cycle read and write strobes
// Notes:   read data is valid one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - writing one to bit 31 of command word starts a nonvolatile store
// - writing one to bit 30 starts recall of defaults from nonvolatile memory
// - bit 29 clears all faults; bit 28 clears the retry counter
// - bits 19..11 hold forced angle, applied modulo 360 degrees
// - device clears the keepalive bit after the host sets it
// - current gains decoded at F0h, speed gains at F2h
// - monitor output controls decoded at F4h and F6h
// - debug override word at ECh resets zero; loop force word at EEh
// - override bit 31 takes speed command from digital speed field
// - bit 15 of debug word selects open loop commutation
// - angle source select picks forced angle when one, else configured
module motor_ctrl_command_regs
    import motor_cmd_pkg::*;
(
    input  wire logic               i_clk,
    input  wire logic               i_rst_b,
    input  wire logic               i_wr_en,
    input  wire logic               i_rd_en,
    input  wire logic [ADDR_W-1:0]  i_addr,
    input  wire logic [DATA_W-1:0]  i_wr_data,
    input  wire logic               i_nvm_done,
    input  wire logic [ANGLE_W-1:0] i_cfg_align_angle,
    output logic      [DATA_W-1:0]  o_rd_data,
    output logic                    o_rd_valid,
    output logic                    o_nvm_store_cmd,
    output logic                    o_nvm_recall_cmd,
    output logic                    o_fault_clear_cmd,
    output logic                    o_retry_counter_clear_cmd,
    output logic                    o_keepalive_seen,
    output logic [ANGLE_W-1:0]      o_align_angle,
    output logic                    o_speed_from_digital,
    output logic [SPEED_W-1:0]      o_digital_speed,
    output logic                    o_open_loop_select,
    output logic                    o_force_align_en,
    output logic                    o_force_slow_cycle_en,
    output logic                    o_force_ipd_en,
    output logic                    o_force_isd_en,
    output logic [IQ_W-1:0]         o_forced_iq_ref,
    output logic [DATA_W-1:0]       o_debug_loop_force_word,
    output logic [DATA_W-1:0]       o_current_loop_gains,
    output logic [DATA_W-1:0]       o_speed_loop_gains,
    output logic [DATA_W-1:0]       o_monitor_out_one_ctrl,
    output logic [DATA_W-1:0]       o_monitor_out_two_ctrl
);
    logic               wr_cmd;
    logic               wr_dbg1;
    logic               wr_dbg2;
    logic               wr_cur;
    logic               wr_spd;
    logic               wr_mon1;
    logic               wr_mon2;

    logic [DATA_W-1:0]  debug_override_word;
    logic [DATA_W-1:0]  debug_loop_force_word;
    logic [DATA_W-1:0]  current_loop_gains;
    logic [DATA_W-1:0]  speed_loop_gains;
    logic [DATA_W-1:0]  monitor_out_one_ctrl;
    logic [DATA_W-1:0]  monitor_out_two_ctrl;
    logic [ANGLE_W-1:0] forced_angle;
    logic               store_busy;
    logic               recall_busy;
    logic               keepalive_bit;
    logic [DATA_W-1:0]  rd_data;
    logic               rd_valid;

    logic [DATA_W-1:0]  next_debug_override_word;
    logic [DATA_W-1:0]  next_debug_loop_force_word;
    logic [DATA_W-1:0]  next_current_loop_gains;
    logic [DATA_W-1:0]  next_speed_loop_gains;
    logic [DATA_W-1:0]  next_monitor_out_one_ctrl;
    logic [DATA_W-1:0]  next_monitor_out_two_ctrl;
    logic [ANGLE_W-1:0] next_forced_angle;
    logic               next_store_busy;
    logic               next_recall_busy;
    logic               next_keepalive_bit;
    logic [DATA_W-1:0]  next_rd_data;
    logic               next_rd_valid;
    logic [CMD_N-1:0]   cmd_bits;
    logic [CMD_N-1:0]   cmd_pulse;

    // address decode; other offsets are ignored
    assign wr_cmd  = i_wr_en && (i_addr == OFS_DEVICE_CMD);
    assign wr_dbg1 = i_wr_en && (i_addr == OFS_DEBUG_OVERRIDE);
    assign wr_dbg2 = i_wr_en && (i_addr == OFS_DEBUG_LOOP);
    assign wr_cur  = i_wr_en && (i_addr == OFS_CURRENT_GAINS);
    assign wr_spd  = i_wr_en && (i_addr == OFS_SPEED_GAINS);
    assign wr_mon1 = i_wr_en && (i_addr == OFS_MONITOR_ONE);
    assign wr_mon2 = i_wr_en && (i_addr == OFS_MONITOR_TWO);

    always_comb begin
        next_debug_override_word   = wr_dbg1 ? i_wr_data : debug_override_word;
        next_debug_loop_force_word = wr_dbg2 ? i_wr_data : debug_loop_force_word;
        next_current_loop_gains    = wr_cur  ? i_wr_data : current_loop_gains;
        next_speed_loop_gains      = wr_spd  ? i_wr_data : speed_loop_gains;
        next_monitor_out_one_ctrl  = wr_mon1 ? i_wr_data : monitor_out_one_ctrl;
        next_monitor_out_two_ctrl  = wr_mon2 ? i_wr_data : monitor_out_two_ctrl;
        // reserved command bits are never stored
        next_forced_angle = wr_cmd ? i_wr_data[CMD_ANGLE_MSB:CMD_ANGLE_LSB]
                                   : forced_angle;
        // busy flags: a new command wins over completion
        next_store_busy = store_busy;
        if (i_nvm_done) begin
            next_store_busy = 1'b0;
        end
        if (wr_cmd && i_wr_data[CMD_NVM_STORE_BIT]) begin
            next_store_busy = 1'b1;
        end
        next_recall_busy = recall_busy;
        if (i_nvm_done) begin
            next_recall_busy = 1'b0;
        end
        if (wr_cmd && i_wr_data[CMD_NVM_RECALL_BIT]) begin
            next_recall_busy = 1'b1;
        end
        // self-clearing keepalive: high only in the cycle after a write
        next_keepalive_bit = wr_cmd && i_wr_data[CMD_KEEPALIVE_BIT];
    end

    always_comb begin
        next_rd_valid = i_rd_en;
        next_rd_data  = WORD_ZERO;
        if (i_rd_en) begin
            unique case (i_addr)
                OFS_DEVICE_CMD: begin
                    next_rd_data[CMD_NVM_STORE_BIT]  = store_busy;
                    next_rd_data[CMD_NVM_RECALL_BIT] = recall_busy;
                    next_rd_data[CMD_KEEPALIVE_BIT]  = keepalive_bit;
                end
                OFS_CURRENT_GAINS: next_rd_data = current_loop_gains;
                OFS_SPEED_GAINS:   next_rd_data = speed_loop_gains;
                OFS_MONITOR_ONE:   next_rd_data = monitor_out_one_ctrl;
                OFS_MONITOR_TWO:   next_rd_data = monitor_out_two_ctrl;
                default:           next_rd_data = WORD_ZERO;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            debug_override_word   <= WORD_ZERO;
            debug_loop_force_word <= WORD_ZERO;
            current_loop_gains    <= CURRENT_GAINS_RST;
            speed_loop_gains      <= SPEED_GAINS_RST;
            monitor_out_one_ctrl  <= MONITOR_ONE_RST;
            monitor_out_two_ctrl  <= MONITOR_TWO_RST;
            forced_angle          <= '0;
            store_busy            <= 1'b0;
            recall_busy           <= 1'b0;
            keepalive_bit         <= 1'b0;
            rd_data               <= WORD_ZERO;
            rd_valid              <= 1'b0;
        end else begin
            debug_override_word   <= next_debug_override_word;
            debug_loop_force_word <= next_debug_loop_force_word;
            current_loop_gains    <= next_current_loop_gains;
            speed_loop_gains      <= next_speed_loop_gains;
            monitor_out_one_ctrl  <= next_monitor_out_one_ctrl;
            monitor_out_two_ctrl  <= next_monitor_out_two_ctrl;
            forced_angle          <= next_forced_angle;
            store_busy            <= next_store_busy;
            recall_busy           <= next_recall_busy;
            keepalive_bit         <= next_keepalive_bit;
            rd_data               <= next_rd_data;
            rd_valid              <= next_rd_valid;
        end
    end

    always_comb begin
        cmd_bits               = '0;
        cmd_bits[PULSE_STORE]  = i_wr_data[CMD_NVM_STORE_BIT];
        cmd_bits[PULSE_RECALL] = i_wr_data[CMD_NVM_RECALL_BIT];
        cmd_bits[PULSE_FAULT]  = i_wr_data[CMD_FAULT_CLR_BIT];
        cmd_bits[PULSE_RETRY]  = i_wr_data[CMD_RETRY_CLR_BIT];
    end

    cmd_pulse_gen u_pulse (
        .i_clk    (i_clk),
        .i_rst_b  (i_rst_b),
        .i_wr_hit (wr_cmd),
        .i_bits   (cmd_bits),
        .o_pulse  (cmd_pulse)
    );

    align_angle_sel u_angle (
        .i_clk           (i_clk),
        .i_rst_b         (i_rst_b),
        .i_select_forced (debug_override_word[DBG_ANGLE_SEL_BIT]),
        .i_forced_angle  (forced_angle),
        .i_cfg_angle     (i_cfg_align_angle),
        .o_angle         (o_align_angle)
    );

    assign o_nvm_store_cmd           = cmd_pulse[PULSE_STORE];
    assign o_nvm_recall_cmd          = cmd_pulse[PULSE_RECALL];
    assign o_fault_clear_cmd         = cmd_pulse[PULSE_FAULT];
    assign o_retry_counter_clear_cmd = cmd_pulse[PULSE_RETRY];
    assign o_keepalive_seen          = keepalive_bit;
    assign o_speed_from_digital      = debug_override_word[DBG_OVERRIDE_BIT];
    assign o_digital_speed           = debug_override_word[DBG_SPEED_MSB:DBG_SPEED_LSB];
    assign o_open_loop_select        = debug_override_word[DBG_OPEN_LOOP_BIT];
    assign o_force_align_en          = debug_override_word[DBG_FORCE_ALIGN_BIT];
    assign o_force_slow_cycle_en     = debug_override_word[DBG_FORCE_SLOW_BIT];
    assign o_force_ipd_en            = debug_override_word[DBG_FORCE_IPD_BIT];
    assign o_force_isd_en            = debug_override_word[DBG_FORCE_ISD_BIT];
    assign o_forced_iq_ref           = debug_override_word[DBG_IQ_MSB:DBG_IQ_LSB];
    assign o_debug_loop_force_word   = debug_loop_force_word;
    assign o_current_loop_gains      = current_loop_gains;
    assign o_speed_loop_gains        = speed_loop_gains;
    assign o_monitor_out_one_ctrl    = monitor_out_one_ctrl;
    assign o_monitor_out_two_ctrl    = monitor_out_two_ctrl;
    assign o_rd_data                 = rd_data;
    assign o_rd_valid                = rd_valid;

    property p_store;
        @(posedge i_clk) disable iff (!i_rst_b)
        wr_cmd && i_wr_data[CMD_NVM_STORE_BIT]
            |=> o_nvm_store_cmd ##0 store_busy;
    endproperty
    a_store: assert property (p_store)
        else $error("store command not issued after write");

    property p_recall;
        @(posedge i_clk) disable iff (!i_rst_b)
        (wr_cmd && i_wr_data[CMD_NVM_RECALL_BIT]) |=> o_nvm_recall_cmd && recall_busy;
    endproperty
    a_recall: assert property (p_recall)
        else $error("recall command not issued after write");

    property p_fault_clear;
        @(posedge i_clk) disable iff (!i_rst_b)
        o_fault_clear_cmd || o_retry_counter_clear_cmd
            |-> $past(wr_cmd) && ($past(i_wr_data[CMD_FAULT_CLR_BIT]) == o_fault_clear_cmd)
                && ($past(i_wr_data[CMD_RETRY_CLR_BIT]) == o_retry_counter_clear_cmd);
    endproperty
    a_fault_clear: assert property (p_fault_clear)
        else $error("clear pulse without matching command write");

    property p_keepalive;
        @(posedge i_clk) disable iff (!i_rst_b)
        keepalive_bit ##1 !wr_cmd |=> !keepalive_bit;
    endproperty
    a_keepalive: assert property (p_keepalive)
        else $error("keepalive bit not cleared by device");

    property p_reserved;
        @(posedge i_clk) disable iff (!i_rst_b)
        i_rd_en && (i_addr == OFS_DEVICE_CMD)
            |=> o_rd_valid && (o_rd_data[27:20] == 8'h00) && (o_rd_data[19:11] == 9'h000)
                && (o_rd_data[9:0] == 10'h000);
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("write-only command bits visible on read");

    property p_gains;
        @(posedge i_clk) disable iff (!i_rst_b)
        wr_spd ##1 (i_rd_en && !i_wr_en && (i_addr == OFS_SPEED_GAINS))
            |=> o_rd_valid && (o_rd_data == $past(i_wr_data, 2));
    endproperty
    a_gains: assert property (p_gains)
        else $error("speed gains readback mismatch");

    property p_monitor;
        @(posedge i_clk) disable iff (!i_rst_b)
        wr_mon2 |=> (o_monitor_out_two_ctrl == $past(i_wr_data)) && $stable(o_monitor_out_one_ctrl);
    endproperty
    a_monitor: assert property (p_monitor)
        else $error("second monitor control not decoded at its offset");

    property p_debug_read;
        @(posedge i_clk) disable iff (!i_rst_b)
        i_rd_en && ((i_addr == OFS_DEBUG_OVERRIDE) || (i_addr == OFS_DEBUG_LOOP))
            |=> o_rd_valid && (o_rd_data == WORD_ZERO);
    endproperty
    a_debug_read: assert property (p_debug_read)
        else $error("write-only debug word returned data");

    property p_override;
        @(posedge i_clk) disable iff (!i_rst_b)
        wr_dbg1 |=> (o_speed_from_digital == $past(i_wr_data[DBG_OVERRIDE_BIT]))
            && (o_open_loop_select == $past(i_wr_data[DBG_OPEN_LOOP_BIT]))
            && (o_digital_speed == $past(i_wr_data[DBG_SPEED_MSB:DBG_SPEED_LSB]));
    endproperty
    a_override: assert property (p_override)
        else $error("debug override fields not applied");

    property p_busy_clear;
        @(posedge i_clk) disable iff (!i_rst_b)
        i_nvm_done && !wr_cmd |=> !store_busy && !recall_busy;
    endproperty
    a_busy_clear: assert property (p_busy_clear)
        else $error("busy flag not released by nonvolatile completion");
endmodule
`default_nettype wire

// [nvm_engine_model.sv]
// Purpose: stand-in for the nonvolatile engine and config store
// Assumes: store and recall requests arrive as one-cycle pulses
// Notes:   done pulse follows the last request after DONE_DELAY cycles
`timescale 1ns/1ps
`default_nettype none
module nvm_engine_model #(
    parameter int         DONE_DELAY = 20,
    parameter logic [8:0] CFG_ANGLE  = 9'h05A
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_start,
    output logic            o_done,
    output logic [8:0]      o_cfg_angle
);
    int cnt;
    assign o_cfg_angle = CFG_ANGLE;
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt    <= 0;
            o_done <= 1'b0;
        end else begin
            o_done <= (cnt == 1);
            if (i_start) begin
                cnt <= DONE_DELAY;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule
`default_nettype wire

// [tb.sv]
// Purpose: self-checking bench for the motor command register bank
// Assumes: host strobes driven at the falling edge, one cycle each
// Notes:   command pulses are counted by a monitor, not sampled once
`timescale 1ns/1ps
`default_nettype none
module tb
    import motor_cmd_pkg::*;
;
    logic        i_clk, i_rst_b, i_wr_en, i_rd_en;
    logic [11:0] i_addr;
    logic [31:0] i_wr_data;
    wire logic   i_nvm_done, o_rd_valid, o_nvm_store_cmd, o_nvm_recall_cmd, o_fault_clear_cmd;
    wire logic   o_retry_counter_clear_cmd, o_keepalive_seen, o_speed_from_digital;
    wire logic   o_open_loop_select, o_force_align_en, o_force_slow_cycle_en, o_force_ipd_en;
    wire logic   o_force_isd_en;
    wire logic [8:0]  i_cfg_align_angle, o_align_angle;
    wire logic [14:0] o_digital_speed;
    wire logic [9:0]  o_forced_iq_ref;
    wire logic [31:0] o_rd_data, o_debug_loop_force_word, o_current_loop_gains;
    wire logic [31:0] o_speed_loop_gains, o_monitor_out_one_ctrl, o_monitor_out_two_ctrl;
    int          err_total, n_compared;
    int          pc[5];
    logic [11:0] offs[7] = '{12'h0EA, 12'h0EC, 12'h0EE, 12'h0F0, 12'h0F2, 12'h0F4, 12'h0F6};

    motor_ctrl_command_regs u_dut (.i_clk, .i_rst_b, .i_wr_en, .i_rd_en, .i_addr, .i_wr_data,
        .i_nvm_done, .i_cfg_align_angle, .o_rd_data, .o_rd_valid, .o_nvm_store_cmd,
        .o_nvm_recall_cmd, .o_fault_clear_cmd, .o_retry_counter_clear_cmd, .o_keepalive_seen,
        .o_align_angle, .o_speed_from_digital, .o_digital_speed, .o_open_loop_select,
        .o_force_align_en, .o_force_slow_cycle_en, .o_force_ipd_en, .o_force_isd_en,
        .o_forced_iq_ref, .o_debug_loop_force_word, .o_current_loop_gains,
        .o_speed_loop_gains, .o_monitor_out_one_ctrl, .o_monitor_out_two_ctrl);
    nvm_engine_model u_nvm (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_start(o_nvm_store_cmd | o_nvm_recall_cmd), .o_done(i_nvm_done),
        .o_cfg_angle(i_cfg_align_angle));

    always #5 i_clk = ~i_clk;
    always @(negedge i_clk) begin
        pc[0] += int'(o_nvm_store_cmd === 1'b1);
        pc[1] += int'(o_nvm_recall_cmd === 1'b1);
        pc[2] += int'(o_fault_clear_cmd === 1'b1);
        pc[3] += int'(o_retry_counter_clear_cmd === 1'b1);
        pc[4] += int'(o_keepalive_seen === 1'b1);
    end

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(negedge i_clk);
        i_wr_en = 1'b1;
        i_addr = a;
        i_wr_data = d;
        @(negedge i_clk);
        i_wr_en = 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        int n;
        @(negedge i_clk);
        i_rd_en = 1'b1;
        i_addr = a;
        @(negedge i_clk);
        i_rd_en = 1'b0;
        n = 0;
        while (o_rd_valid !== 1'b1 && n < 4) begin
            @(negedge i_clk);
            n++;
        end
        if (n == 4) begin
            err_total++;
            $display("[FAIL] %0t no read answer", $time);
            complete_run();
        end else begin
            chk(o_rd_data, exp, "read data");
        end
    endtask
    task automatic pulses(input int s, input int r, input int f, input int c, input int k);
        repeat (3) @(negedge i_clk);
        chk(32'(pc[0]), 32'(s), "store pulses");
        chk(32'(pc[1]), 32'(r), "recall pulses");
        chk(32'(pc[2]), 32'(f), "fault clear pulses");
        chk(32'(pc[3]), 32'(c), "retry clear pulses");
        chk(32'(pc[4]), 32'(k), "keepalive pulses");
        foreach (pc[j]) pc[j] = 0;
    endtask

    initial begin
        logic [31:0] dbg;
        foreach (pc[j]) pc[j] = 0;
        {i_clk, i_rst_b, i_wr_en, i_rd_en, i_addr, i_wr_data} = '0;
        err_total = 0;
        n_compared = 0;
        repeat (5) @(negedge i_clk);
        i_rst_b = 1'b1;
        foreach (offs[j]) rd_chk(offs[j], 32'h0000_0000);
        chk({o_speed_from_digital, o_digital_speed, o_open_loop_select, o_forced_iq_ref},
            32'h0, "debug word reset");
        $display("test reset values done");
        for (int j = 3; j < 7; j++) wr(offs[j], 32'hA5A5_0000 | 32'(j));
        rd_chk(12'h0F8, 32'h0000_0000);
        for (int j = 3; j < 7; j++) rd_chk(offs[j], 32'hA5A5_0000 | 32'(j));
        chk(o_current_loop_gains, 32'hA5A5_0003, "current gains");
        chk(o_speed_loop_gains, 32'hA5A5_0004, "speed gains");
        chk(o_monitor_out_one_ctrl, 32'hA5A5_0005, "monitor one");
        chk(o_monitor_out_two_ctrl, 32'hA5A5_0006, "monitor two");
        @(negedge i_clk);
        {i_wr_en, i_addr, i_wr_data} = {1'b1, 12'h0F2, 32'h5A5A_1234};
        @(negedge i_clk);
        {i_wr_en, i_rd_en} = 2'b01;
        @(negedge i_clk);
        i_rd_en = 1'b0;
        chk(o_rd_data, 32'h5A5A_1234, "speed gains read after write");
        $display("test gain and monitor words done");
        wr(12'h0EA, 32'hF000_0400);
        rd_chk(12'h0EA, 32'hC000_0000);
        pulses(1, 1, 1, 1, 1);
        repeat (30) @(negedge i_clk);
        rd_chk(12'h0EA, 32'h0000_0000);
        wr(12'h0EA, 32'h2000_0000);
        wr(12'h0EA, 32'h2000_0400);
        pulses(0, 0, 2, 0, 1);
        wr(12'h0EA, 32'h0FF0_03FF);
        rd_chk(12'h0EA, 32'h0000_0000);
        pulses(0, 0, 0, 0, 0);
        $display("test command word done");
        dbg = 32'h8000_C555 | (32'h1234 << 16);
        wr(12'h0EC, dbg);
        wr(12'h0EE, 32'h1357_9BDF);
        rd_chk(12'h0EC, 32'h0000_0000);
        chk(o_speed_from_digital, 32'h1, "speed source");
        chk(o_digital_speed, 32'h1234, "digital speed");
        chk(o_open_loop_select, 32'h1, "open loop");
        chk({o_force_align_en, o_force_slow_cycle_en, o_force_ipd_en, o_force_isd_en},
            32'h8, "force enables");
        chk(o_forced_iq_ref, 32'h155, "iq reference");
        chk(o_debug_loop_force_word, 32'h1357_9BDF, "loop force word");
        wr(12'h0EA, 32'h000B_9000);
        repeat (3) @(negedge i_clk);
        chk(o_align_angle, 32'h00A, "wrapped angle");
        wr(12'h0EA, 32'h000B_3800);
        repeat (3) @(negedge i_clk);
        chk(o_align_angle, 32'h167, "angle below turn");
        wr(12'h0EC, 32'h0000_4000);
        repeat (3) @(negedge i_clk);
        chk(o_align_angle, 32'h05A, "configured angle");
        chk(o_open_loop_select, 32'h0, "closed loop");
        chk(o_speed_from_digital, 32'h0, "analog speed");
        $display("test debug word done");
        complete_run();
    end
endmodule
`default_nettype wire
